//--- hdl/pwm16_pkg.sv
// constants and types shared by the waveform timer
package pwm16_pkg;
    localparam int          CNT_W        = 16;
    localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT     = 16'h00FF;
    localparam logic [15:0] TOP_9BIT     = 16'h01FF;
    localparam logic [15:0] TOP_10BIT    = 16'h03FF;
    localparam logic [15:0] ONE          = 16'h0001;
    // waveform mode select codes
    localparam logic [3:0]  WM_PC8       = 4'h1;
    localparam logic [3:0]  WM_PC9       = 4'h2;
    localparam logic [3:0]  WM_PC10      = 4'h3;
    localparam logic [3:0]  WM_FP8       = 4'h5;
    localparam logic [3:0]  WM_FP9       = 4'h6;
    localparam logic [3:0]  WM_FP10      = 4'h7;
    localparam logic [3:0]  WM_PC_CAP    = 4'hA;
    localparam logic [3:0]  WM_PC_CMPA   = 4'hB;
    localparam logic [3:0]  WM_FP_CAP    = 4'hE;
    localparam logic [3:0]  WM_FP_CMPA   = 4'hF;
    // channel output mode codes
    localparam logic [1:0]  OM_OFF       = 2'h0;
    localparam logic [1:0]  OM_TOGGLE    = 2'h1;
    localparam logic [1:0]  OM_NONINV    = 2'h2;
    localparam logic [1:0]  OM_INV       = 2'h3;
    // prescaler select codes: stop, 1, 8, 64, 256, 1024
    localparam logic [2:0]  PS_STOP      = 3'h0;
    localparam logic [2:0]  PS_DIV1      = 3'h1;
    localparam logic [2:0]  PS_DIV8      = 3'h2;
    localparam logic [2:0]  PS_DIV64     = 3'h3;
    localparam logic [2:0]  PS_DIV256    = 3'h4;
    localparam logic [2:0]  PS_DIV1024   = 3'h5;
    localparam int          PS_W         = 10;
    localparam logic [9:0]  PS_M8        = 10'h007;
    localparam logic [9:0]  PS_M64       = 10'h03F;
    localparam logic [9:0]  PS_M256      = 10'h0FF;
    localparam logic [9:0]  PS_M1024     = 10'h3FF;
    localparam logic [9:0]  PS_ZERO      = 10'h000;
    localparam logic [9:0]  PS_ONE       = 10'h001;

    // count direction, gray order: up then down
    typedef enum logic [0:0] {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_e;
endpackage : pwm16_pkg

//--- hdl/pwm16_prescaler.sv
// prescaler that issues the one-cycle timer clock enable
`timescale 1ns/100ps
module pwm16_prescaler
    import pwm16_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // divider select
    input  wire logic [2:0] clock_select,
    // timer clock enable
    output logic            tick
);
    import pwm16_pkg::*;

    logic [PS_W-1:0] div_count;
    logic [PS_W-1:0] next_div_count;
    logic            next_tick;
    logic [PS_W-1:0] mask;

    always_comb
    begin
        case (clock_select)
            PS_DIV8:    mask = PS_M8;
            PS_DIV64:   mask = PS_M64;
            PS_DIV256:  mask = PS_M256;
            PS_DIV1024: mask = PS_M1024;
            default:    mask = PS_ZERO;
        endcase
        next_div_count = div_count + PS_ONE;
        next_tick      = 1'b0;
        if (clock_select == PS_STOP || clock_select > PS_DIV1024)
        begin
            next_div_count = PS_ZERO;
        end
        else if ((div_count & mask) == mask)
        begin
            // period is N system cycles
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            div_count <= PS_ZERO;
            tick      <= 1'b0;
        end
        else
        begin
            div_count <= next_div_count;
            tick      <= next_tick;
        end
    end
endmodule // pwm16_prescaler

//--- hdl/pwm16_out_pin.sv
// pin gating of one waveform output
`timescale 1ns/100ps
module pwm16_out_pin (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // waveform and enables
    input  wire logic wave,
    input  wire logic pin_direction_bit,
    input  wire logic wave_output_enable,
    input  wire logic port_value,
    // pin
    output logic      pin_level,
    output logic      pin_oe
);
    logic next_pin_level;
    logic next_pin_oe;

    always_comb
    begin
        // waveform only overrides the port when both bits are set
        next_pin_oe    = pin_direction_bit;
        next_pin_level = (pin_direction_bit && wave_output_enable) ?
                         wave : port_value;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_level <= 1'b0;
            pin_oe    <= 1'b0;
        end
        else
        begin
            pin_level <= next_pin_level;
            pin_oe    <= next_pin_oe;
        end
    end
endmodule // pwm16_out_pin

//--- hdl/pwm16_timer.sv
// 16-bit timer with fast and phase correct pwm waveform generation
//==========================================================================
`timescale 1ns/100ps
module pwm16_timer
    import pwm16_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // configuration
    input  wire logic [3:0]  waveform_mode_select,
    input  wire logic [1:0]  chan_a_output_mode,
    input  wire logic [1:0]  chan_b_output_mode,
    input  wire logic [2:0]  clock_select,
    // compare and top register writes
    input  wire logic [15:0] write_data,
    input  wire logic        compare_a_write,
    input  wire logic        compare_b_write,
    input  wire logic        capture_top_write,
    // flag clears, one cycle pulses
    input  wire logic        overflow_clear,
    input  wire logic        compare_a_clear,
    input  wire logic        compare_b_clear,
    input  wire logic        capture_clear,
    // pin control
    input  wire logic        pin_direction_bit_a,
    input  wire logic        pin_direction_bit_b,
    input  wire logic        wave_output_enable_a,
    input  wire logic        wave_output_enable_b,
    input  wire logic        port_value_a,
    input  wire logic        port_value_b,
    // status
    output logic [15:0]      counter_value,
    output logic [15:0]      compare_a_value,
    output logic [15:0]      compare_b_value,
    output logic [15:0]      capture_top_value,
    output logic             overflow_flag,
    output logic             compare_a_flag,
    output logic             compare_b_flag,
    output logic             capture_flag,
    // pins
    output logic             wave_out_a,
    output logic             wave_out_a_oe,
    output logic             wave_out_b,
    output logic             wave_out_b_oe
);
    import pwm16_pkg::*;

    //======================================================================
    // mode decode
    function automatic logic is_fast(input logic [3:0] m);
        return m == WM_FP8 || m == WM_FP9 || m == WM_FP10 ||
               m == WM_FP_CAP || m == WM_FP_CMPA;
    endfunction

    function automatic logic is_phase(input logic [3:0] m);
        return m == WM_PC8 || m == WM_PC9 || m == WM_PC10 ||
               m == WM_PC_CAP || m == WM_PC_CMPA;
    endfunction

    function automatic logic [15:0] fixed_mask(input logic [3:0] m);
        case (m)
            WM_PC8, WM_FP8:   return TOP_8BIT;
            WM_PC9, WM_FP9:   return TOP_9BIT;
            WM_PC10, WM_FP10: return TOP_10BIT;
            default:          return CNT_MAX;
        endcase
    endfunction

    logic        tick;
    logic        fast;
    logic        phase;
    logic        top_is_cap;
    logic        top_is_cmpa;
    logic [15:0] top;
    logic        at_top;
    logic        at_bottom;
    logic        match_a;
    logic        match_b;

    always_comb
    begin
        fast        = is_fast(waveform_mode_select);
        phase       = is_phase(waveform_mode_select);
        top_is_cap  = waveform_mode_select == WM_PC_CAP ||
                      waveform_mode_select == WM_FP_CAP;
        top_is_cmpa = waveform_mode_select == WM_PC_CMPA ||
                      waveform_mode_select == WM_FP_CMPA;
        // top select, fixed or register based
        if (top_is_cap)
            top = capture_top_value;
        else if (top_is_cmpa)
            top = compare_a_value;
        else
            top = fixed_mask(waveform_mode_select);
        at_top    = counter_value == top;
        at_bottom = counter_value == CNT_BOTTOM;
        // equality only: a top below compare never matches
        match_a   = counter_value == compare_a_value;
        match_b   = counter_value == compare_b_value;
    end

    pwm16_prescaler u_prescaler (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .clock_select (clock_select),
        .tick         (tick)
    );

    //======================================================================
    // compare buffers and capture/top register
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] next_buf_a;
    logic [15:0] next_buf_b;
    logic [15:0] next_compare_a_value;
    logic [15:0] next_compare_b_value;
    logic [15:0] next_capture_top_value;
    logic        load_buffers;

    always_comb
    begin
        // masked on write when top is fixed
        next_buf_a = compare_a_write ?
                     (write_data & fixed_mask(waveform_mode_select)) : buf_a;
        next_buf_b = compare_b_write ?
                     (write_data & fixed_mask(waveform_mode_select)) : buf_b;
        // no double buffer here: lower value makes count run to max
        next_capture_top_value = capture_top_write ? write_data
                                                   : capture_top_value;
        // update at top in both pwm families
        load_buffers = tick && at_top && (fast || phase);
        next_compare_a_value = load_buffers ? buf_a : compare_a_value;
        next_compare_b_value = load_buffers ? buf_b : compare_b_value;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            buf_a             <= CNT_BOTTOM;
            buf_b             <= CNT_BOTTOM;
            compare_a_value   <= CNT_BOTTOM;
            compare_b_value   <= CNT_BOTTOM;
            capture_top_value <= CNT_BOTTOM;
        end
        else
        begin
            buf_a             <= next_buf_a;
            buf_b             <= next_buf_b;
            compare_a_value   <= next_compare_a_value;
            compare_b_value   <= next_compare_b_value;
            capture_top_value <= next_capture_top_value;
        end
    end

    //======================================================================
    // counter
    dir_e        dir;
    dir_e        next_dir;
    logic [15:0] next_counter_value;

    always_comb
    begin
        next_counter_value = counter_value;
        next_dir           = dir;
        if (tick)
        begin
            if (fast)
            begin
                next_dir = DIR_UP;
                // clear the cycle after top; wraps past max if missed
                next_counter_value = at_top ? CNT_BOTTOM
                                            : counter_value + ONE;
            end
            else if (phase)
            begin
                // top is held one timer cycle, then direction flips
                if (dir == DIR_UP && at_top)
                begin
                    next_dir = DIR_DOWN;
                    next_counter_value = counter_value - ONE;
                end
                else if (dir == DIR_DOWN && at_bottom)
                begin
                    next_dir = DIR_UP;
                    next_counter_value = counter_value + ONE;
                end
                else if (dir == DIR_UP)
                    next_counter_value = counter_value + ONE;
                else
                    next_counter_value = counter_value - ONE;
            end
            else
                next_counter_value = counter_value + ONE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            counter_value <= CNT_BOTTOM;
            dir           <= DIR_UP;
        end
        else
        begin
            counter_value <= next_counter_value;
            dir           <= next_dir;
        end
    end

    //======================================================================
    // flags: a set in the clearing cycle wins
    logic set_ovf;
    logic set_a;
    logic set_b;
    logic set_cap;
    logic next_overflow_flag;
    logic next_compare_a_flag;
    logic next_compare_b_flag;
    logic next_capture_flag;

    always_comb
    begin
        set_ovf = tick && ((fast && at_top) ||
                           (phase && at_bottom));
        // top register flag rides on the top cycle
        set_a   = tick && (match_a || (top_is_cmpa && at_top));
        set_b   = tick && match_b;
        set_cap = tick && top_is_cap && at_top;
        next_overflow_flag  = set_ovf | (overflow_flag  & ~overflow_clear);
        next_compare_a_flag = set_a   | (compare_a_flag & ~compare_a_clear);
        next_compare_b_flag = set_b   | (compare_b_flag & ~compare_b_clear);
        next_capture_flag   = set_cap | (capture_flag   & ~capture_clear);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            overflow_flag  <= 1'b0;
            compare_a_flag <= 1'b0;
            compare_b_flag <= 1'b0;
            capture_flag   <= 1'b0;
        end
        else
        begin
            overflow_flag  <= next_overflow_flag;
            compare_a_flag <= next_compare_a_flag;
            compare_b_flag <= next_compare_b_flag;
            capture_flag   <= next_capture_flag;
        end
    end

    //======================================================================
    // waveform generation
    function automatic logic wave_next(
        input logic       cur,
        input logic [1:0] om,
        input logic       match,
        input logic       toggle_ok
    );
        logic v;
        v = cur;
        if (fast)
        begin
            // compare equal top: match and top actions collide, the match action wins,
            // giving a steady level
            if (om == OM_NONINV)
                v = match ? 1'b1 : (at_top ? 1'b0 : cur);
            else if (om == OM_INV)
                v = match ? 1'b0 : (at_top ? 1'b1 : cur);
            else if (om == OM_TOGGLE && toggle_ok && match)
                v = ~cur;
        end
        else if (phase && match)
        begin
            // up match clears, down match sets for mode two
            // top and bottom are met once a period, so a match there
            // gives a steady level instead of a lone edge
            if (om == OM_NONINV)
                v = at_top ? 1'b1 : (at_bottom ? 1'b0 : (dir == DIR_DOWN));
            else if (om == OM_INV)
                v = at_top ? 1'b0 : (at_bottom ? 1'b1 : (dir == DIR_UP));
        end
        return v;
    endfunction

    logic wave_a;
    logic wave_b;
    logic next_wave_a;
    logic next_wave_b;

    always_comb
    begin
        next_wave_a = wave_a;
        next_wave_b = wave_b;
        if (tick)
        begin
            next_wave_a = wave_next(wave_a, chan_a_output_mode, match_a, 1'b1);
            next_wave_b = wave_next(wave_b, chan_b_output_mode, match_b, 1'b0);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end
        else
        begin
            wave_a <= next_wave_a;
            wave_b <= next_wave_b;
        end
    end

    pwm16_out_pin u_pin_a (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .wave               (wave_a),
        .pin_direction_bit  (pin_direction_bit_a),
        .wave_output_enable (wave_output_enable_a),
        .port_value         (port_value_a),
        .pin_level          (wave_out_a),
        .pin_oe             (wave_out_a_oe)
    );

    pwm16_out_pin u_pin_b (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .wave               (wave_b),
        .pin_direction_bit  (pin_direction_bit_b),
        .wave_output_enable (wave_output_enable_b),
        .port_value         (port_value_b),
        .pin_level          (wave_out_b),
        .pin_oe             (wave_out_b_oe)
    );

    //======================================================================
    // checks
    AST_OVF_FAST: assert property (@(posedge clk_sys) disable iff (rst)
        tick && fast && at_top |=> overflow_flag)
        else $error("overflow flag missing at fast top");
    AST_TOPFLAG: assert property (@(posedge clk_sys) disable iff (rst)
        tick && fast && top_is_cap && at_top |=> capture_flag && overflow_flag)
        else $error("capture flag not with overflow");
    AST_LOAD_A: assert property (@(posedge clk_sys) disable iff (rst)
        load_buffers |=> compare_a_value == $past(buf_a))
        else $error("compare a not loaded at top");
    AST_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        tick && fast && at_top |=> counter_value == CNT_BOTTOM)
        else $error("counter not cleared after top");
    AST_NO_TICK: assert property (@(posedge clk_sys) disable iff (rst)
        !tick |=> $stable(counter_value))
        else $error("counter moved without enable");
    AST_OVF_PC: assert property (@(posedge clk_sys) disable iff (rst)
        tick && phase && at_bottom |=> overflow_flag)
        else $error("overflow flag missing at bottom");
    AST_REVERSE: assert property (@(posedge clk_sys) disable iff (rst)
        tick && phase && dir == DIR_UP && at_top && top != CNT_BOTTOM
        |=> dir == DIR_DOWN && counter_value == $past(top) - ONE)
        else $error("phase correct top not reversed");
    AST_MATCH: assert property (@(posedge clk_sys) disable iff (rst)
        tick && match_b |=> compare_b_flag)
        else $error("compare b flag missing");
    AST_NONINV: assert property (@(posedge clk_sys) disable iff (rst)
        tick && fast && chan_b_output_mode == OM_NONINV && match_b
        |=> wave_b)
        else $error("fast pwm did not set on match");
endmodule // pwm16_timer

//--- tb/pwm16_load.sv
// load model that measures period and high time seen on one pin
`timescale 1ns/100ps
module pwm16_load (
    // clock and pin
    input  wire logic        clk_sys,
    input  wire logic        pin_level,
    input  wire logic        pin_oe,
    // measurements in clock cycles
    output logic [15:0]      period,
    output logic [15:0]      high_time
);
    logic [15:0] run;
    logic [15:0] hi;
    logic        last;
    // an undriven pin reads low through the load's pull-down
    wire  logic  level = pin_oe & pin_level;
    //==========================================================================
    // edge timing
    always @(posedge clk_sys)
    begin
        last <= level;
        run  <= (level & !last) ? 16'h0001 : run + 16'h0001;
        hi   <= (level & !last) ? 16'h0001 : hi + {15'h0000, level};
        if (level & !last)
        begin
            period    <= run;
            high_time <= hi;
        end
    end
endmodule // pwm16_load

//--- tb/pwm16_timer_bench.sv
// self-checking bench for the waveform timer
`timescale 1ns/100ps
module pwm16_timer_bench;
    import pwm16_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  wm = 4'h0;
    logic [1:0]  oma = OM_OFF, omb = OM_OFF;
    logic [2:0]  cs = PS_DIV1;
    logic [15:0] wd = 16'h0000;
    logic        wa = 0, wb = 0, wt = 0, clr = 0;
    logic        dira = 1, dirb = 1, ena = 1, enb = 1, pva = 0, pvb = 0;
    logic [15:0] cnt, cva, cvb, ctv, pa, pb, ha, hb;
    logic        ovf, fa, fb, fc, wo_a, oe_a, wo_b, oe_b;
    int          mismatches = 0;
    int          n_tests = 0;
    //==========================================================================
    // design and loads
    pwm16_timer uut (
        .clk_sys(clk), .rst(rst), .waveform_mode_select(wm),
        .chan_a_output_mode(oma), .chan_b_output_mode(omb),
        .clock_select(cs), .write_data(wd), .compare_a_write(wa),
        .compare_b_write(wb), .capture_top_write(wt),
        .overflow_clear(clr), .compare_a_clear(clr),
        .compare_b_clear(clr), .capture_clear(clr),
        .pin_direction_bit_a(dira), .pin_direction_bit_b(dirb),
        .wave_output_enable_a(ena), .wave_output_enable_b(enb),
        .port_value_a(pva), .port_value_b(pvb), .counter_value(cnt),
        .compare_a_value(cva), .compare_b_value(cvb),
        .capture_top_value(ctv), .overflow_flag(ovf),
        .compare_a_flag(fa), .compare_b_flag(fb), .capture_flag(fc),
        .wave_out_a(wo_a), .wave_out_a_oe(oe_a), .wave_out_b(wo_b),
        .wave_out_b_oe(oe_b));
    pwm16_load load_a (.clk_sys(clk), .pin_level(wo_a), .pin_oe(oe_a),
        .period(pa), .high_time(ha));
    pwm16_load load_b (.clk_sys(clk), .pin_level(wo_b), .pin_oe(oe_b),
        .period(pb), .high_time(hb));
    always #2 clk = ~clk;
    //==========================================================================
    // tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one strobe cycle, then an idle cycle so strobes never abut
    task automatic wr(input int sel, input logic [15:0] d);
        wd = d;
        wa = (sel == 0);
        wb = (sel == 1);
        wt = (sel == 2);
        step(1);
        {wa, wb, wt} = 3'h0;
        step(1);
    endtask
    task automatic wait_cnt(input logic [15:0] v);
        int i;
        i = 0;
        while (cnt !== v && i < 70000)
        begin
            step(1);
            i++;
        end
        chk(cnt, v, "count value not reached");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    //==========================================================================
    // tests
    initial
    begin
        step(6);
        rst = 0;
        step(1);
        wm = WM_FP_CAP;
        omb = OM_NONINV;
        wr(2, 16'h0003);
        chk(ctv, 16'h0003, "capture top write");
        wr(1, 16'h0002);
        wait_cnt(16'h0002);
        clr = 1;
        step(1);
        clr = 0;
        chk(ovf, 1'b0, "overflow early");
        step(1);
        chk(cnt, 16'h0000, "clear after top");
        chk(ovf, 1'b1, "overflow at top");
        chk(fc, 1'b1, "capture flag at top");
        chk(fb, 1'b1, "compare b flag over clear");
        step(20);
        chk(pb, 16'd4, "fast period");
        chk(hb, 16'd1, "non-inverted high");
        omb = OM_INV;
        step(40);
        chk(hb, 16'd3, "inverted high");
        cs = PS_DIV8;
        step(120);
        chk(pb, 16'd32, "divided period");
        cs = PS_DIV64;
        step(800);
        chk(pb, 16'd256, "divided period 64");
        cs = PS_DIV1;
        omb = OM_NONINV;
        wr(1, 16'h0003);
        step(12);
        repeat (6)
        begin
            step(1);
            chk(wo_b, 1'b1, "compare at top level");
        end
        $display("fast pwm test done");
        enb = 0;
        pvb = 1;
        step(3);
        chk(wo_b, 1'b1, "port value high");
        pvb = 0;
        step(3);
        chk(wo_b, 1'b0, "port value low");
        dirb = 0;
        enb = 1;
        step(3);
        chk(oe_b, 1'b0, "direction off");
        chk(oe_a, 1'b1, "direction a on");
        dirb = 1;
        $display("pin gating test done");
        wm = WM_FP8;
        wr(0, 16'h1234);
        chk(cva, 16'h0000, "compare a buffered");
        for (int i = 0; i < 600 && cva === 16'h0000; i++)
            step(1);
        chk(cva, 16'h0034, "masked compare load");
        chk(cnt, 16'h0000, "load with clear");
        wr(1, 16'h0000);
        wm = WM_FP_CMPA;
        oma = OM_TOGGLE;
        wr(0, 16'h0000);
        step(600);
        chk(pa, 16'd2, "toggle period");
        chk(ha, 16'd1, "toggle duty");
        chk(fa, 1'b1, "compare a flag at top");
        $display("buffer and toggle test done");
        wm = WM_PC_CAP;
        wr(1, 16'h0001);
        wait_cnt(16'h0003);
        clr = 1;
        step(1);
        clr = 0;
        chk(cnt, 16'h0002, "top held one cycle");
        chk(ovf, 1'b0, "overflow early");
        step(3);
        chk(ovf, 1'b1, "overflow at bottom");
        step(40);
        chk(pb, 16'd6, "dual slope period");
        chk(hb, 16'd2, "dual slope high");
        chk(cvb, 16'h0001, "compare b loaded at top");
        foreach (ha[k])
        begin
            if (k == 0 || k == 3)
            begin
                wr(1, 16'(k));
                step(40);
                repeat (6)
                begin
                    step(1);
                    chk(wo_b, k == 3, "extreme level");
                end
            end
        end
        $display("phase correct test done");
        wm = WM_FP_CAP;
        wr(2, 16'h0040);
        wait_cnt(16'h0030);
        wr(2, 16'h0010);
        wait_cnt(16'hFFFF);
        step(1);
        chk(cnt, 16'h0000, "wrap after miss");
        $display("unbuffered top test done");
        complete_run();
    end
    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule // pwm16_timer_bench
